// [rtl/bpag_consts.svh]
/*
 * Offsets, field positions, reset values and codes of the port A block.
 * Included by the package and the design files; holds definitions only.
 */
`ifndef BPAG_CONSTS_SVH
`define BPAG_CONSTS_SVH

`define BPAG_PINS          8
`define BPAG_ADDR_W        3
`define BPAG_ANA_CH        5

`define BPAG_OFF_PIN_LEVEL 3'h0
`define BPAG_OFF_OUT_LATCH 3'h1
`define BPAG_OFF_DIR       3'h2
`define BPAG_OFF_ADC_CTRL1 3'h3
`define BPAG_OFF_OSC_CFG   3'h4
`define BPAG_OFF_ALT_CTRL  3'h5
`define BPAG_OFF_OWN_STAT  3'h6

`define BPAG_DIR_RST       8'hFF
`define BPAG_LATCH_RST     8'h00
`define BPAG_ADC_RST       6'h00
`define BPAG_OSC_RST       4'h8
`define BPAG_ALT_RST       1'h0

`define BPAG_AMAP_LSB      0
`define BPAG_AMAP_MSB      3
`define BPAG_VREF_LSB      4
`define BPAG_VREF_MSB      5
`define BPAG_AMAP_ALL_ANA  4'hE

`define BPAG_OSC_EC_QCLK   4'h4
`define BPAG_OSC_EC_IO     4'h5
`define BPAG_OSC_INT_IO    4'h8
`define BPAG_OSC_INT_QCLK  4'h9

`define BPAG_PIN_TMR       4
`define BPAG_PIN_SS        5
`define BPAG_PIN_QCLK      6
`define BPAG_PIN_OSCI      7
`define BPAG_PIN_CREF      0

`define BPAG_CLKDIV_W      2

`endif

// [rtl/bpag_pkg.sv]
/*
 * Types of the port A block.
 * Assumes bpag_consts.svh is on the include path.
 */
package bpag_pkg;
   `include "bpag_consts.svh"

   typedef enum logic [2:0] {
      BPAG_P6_PORT = 3'h1,
      BPAG_P6_QCLK = 3'h2,
      BPAG_P6_OSC  = 3'h4
   } bpag_p6_mode_t;

   typedef logic [`BPAG_PINS-1:0] bpag_byte_t;
endpackage

// [rtl/bpag_sync.sv]
/*
 * Two-flop synchroniser for a bus of independent level inputs.
 * Assumes each bit is a slowly changing level from outside the clock domain.
 */
`timescale 1ns/1ns
module bpag_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] raw,
   output logic      [WIDTH-1:0] synced
);
   logic [WIDTH-1:0] meta_ff;

   // first stage feeds only the second stage
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         meta_ff <= '0;
         synced  <= '0;
      end else begin
         meta_ff <= raw;
         synced  <= meta_ff;
      end
   end
endmodule

// [rtl/bpag_port.sv]
/*
 * Eight-pin bidirectional general purpose port with alternate functions:
 * analog channels, comparator reference output, timer clock input,
 * serial slave select, clock-out and oscillator pins.
 * Assumes a plain register port on core_clk and pads resolved outside.
 */
`timescale 1ns/1ns
`include "bpag_consts.svh"

module bpag_port
   import bpag_pkg::*;
#(
   parameter logic [3:0] OSC_CFG_RST = `BPAG_OSC_RST
) (
   input  wire logic                    core_clk,
   input  wire logic                    resetn,
   input  wire logic [`BPAG_ADDR_W-1:0] bus_addr,
   input  wire logic [7:0]              bus_wdata,
   input  wire logic                    bus_wr,
   input  wire logic                    bus_rd,
   output logic      [7:0]              bus_rdata,
   input  wire logic [`BPAG_PINS-1:0]   pad_in,
   output logic      [`BPAG_PINS-1:0]   pad_out,
   output logic      [`BPAG_PINS-1:0]   pad_oe,
   output logic                         timer_ext_clk_in,
   output logic                         timer_clk_valid,
   output logic                         sync_serial_periph_ss_n,
   output logic      [`BPAG_ANA_CH-1:0] analog_ch_en,
   output logic      [1:0]              vref_cfg,
   output logic                         cmp_ref_out_en,
   output logic                         osc_in_en,
   output logic                         osc_out_en,
   output logic                         clk_out_quarter
);

   // software-visible state
   bpag_byte_t                dir_ff;
   bpag_byte_t                latch_ff;
   logic [5:0]                adc_ctrl1_ff;
   logic [3:0]                osc_cfg_ff;
   logic                      cref_en_ff;
   logic [7:0]                rdata_ff;

   // clock-out divider
   logic [`BPAG_CLKDIV_W-1:0] clkdiv_ff;
   logic                      qclk_ff;

   // derived ownership and read path
   bpag_byte_t                pin_sync;
   bpag_byte_t                analog_pin;
   bpag_byte_t                osc_owned;
   bpag_byte_t                alt_owned;
   bpag_byte_t                pin_read;
   bpag_byte_t                dir_read;
   bpag_byte_t                latch_read;
   bpag_byte_t                nxt_pad_out;
   bpag_byte_t                nxt_pad_oe;
   bpag_p6_mode_t             p6_mode;
   logic                      p7_port;
   logic [3:0]                amap;
   logic [7:0]                nxt_rdata;

   // pin levels cross into core_clk before anything reads them
   bpag_sync #(
      .WIDTH (`BPAG_PINS)
   ) u_sync (
      .core_clk (core_clk),
      .resetn   (resetn),
      .raw      (pad_in),
      .synced   (pin_sync)
   );

   // ------------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------------

   // direction bits; all inputs after reset
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         dir_ff <= `BPAG_DIR_RST;
      end else if (bus_wr && bus_addr == `BPAG_OFF_DIR) begin
         dir_ff <= bus_wdata;
      end
   end

   // output latch, reachable through both the port and latch offsets
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         latch_ff <= `BPAG_LATCH_RST;
      end else if (bus_wr && bus_addr == `BPAG_OFF_PIN_LEVEL) begin
         latch_ff <= bus_wdata;
      end else if (bus_wr && bus_addr == `BPAG_OFF_OUT_LATCH) begin
         latch_ff <= bus_wdata;
      end
   end

   // converter control: analog selection and reference choice
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         adc_ctrl1_ff <= `BPAG_ADC_RST;
      end else if (bus_wr && bus_addr == `BPAG_OFF_ADC_CTRL1) begin
         adc_ctrl1_ff <= bus_wdata[5:0];
      end
   end

   // oscillator selection for the two top pins
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         osc_cfg_ff <= OSC_CFG_RST;
      end else if (bus_wr && bus_addr == `BPAG_OFF_OSC_CFG) begin
         osc_cfg_ff <= bus_wdata[3:0];
      end
   end

   // comparator reference output enable
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cref_en_ff <= `BPAG_ALT_RST;
      end else if (bus_wr && bus_addr == `BPAG_OFF_ALT_CTRL) begin
         cref_en_ff <= bus_wdata[0];
      end
   end

   // ------------------------------------------------------------------
   // alternate function decode
   // ------------------------------------------------------------------

   assign amap = adc_ctrl1_ff[`BPAG_AMAP_MSB:`BPAG_AMAP_LSB];

   // channel k is analog while amap <= 14 - k; 0 makes all five analog
   always_comb begin
      analog_pin = '0;
      for (int k = 0; k < `BPAG_ANA_CH; k++) begin
         if (amap <= (`BPAG_AMAP_ALL_ANA - 4'(k))) begin
            if (k < 4) begin
               analog_pin[k] = 1'b1;
            end else begin
               analog_pin[`BPAG_PIN_SS] = 1'b1;
            end
         end
      end
   end

   // pin 6: port, clock-out or oscillator output
   always_comb begin
      if (osc_cfg_ff == `BPAG_OSC_INT_IO || osc_cfg_ff == `BPAG_OSC_EC_IO) begin
         p6_mode = BPAG_P6_PORT;
      end else if (osc_cfg_ff == `BPAG_OSC_INT_QCLK ||
                   osc_cfg_ff == `BPAG_OSC_EC_QCLK) begin
         p6_mode = BPAG_P6_QCLK;
      end else begin
         p6_mode = BPAG_P6_OSC;
      end
   end

   // pin 7 stays a port pin only with the internal oscillator
   assign p7_port = (osc_cfg_ff == `BPAG_OSC_INT_IO) ||
                    (osc_cfg_ff == `BPAG_OSC_INT_QCLK);

   always_comb begin
      osc_owned = '0;
      osc_owned[`BPAG_PIN_QCLK] = (p6_mode != BPAG_P6_PORT);
      osc_owned[`BPAG_PIN_OSCI] = !p7_port;
   end

   // every pin whose driver an alternate function has taken away
   always_comb begin
      alt_owned = osc_owned;
      alt_owned[`BPAG_PIN_CREF] = cref_en_ff;
   end

   // ------------------------------------------------------------------
   // quarter-rate clock out
   // ------------------------------------------------------------------

   // free-running divide by four of core_clk, half duty
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         clkdiv_ff <= '0;
      end else begin
         clkdiv_ff <= clkdiv_ff + `BPAG_CLKDIV_W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         qclk_ff <= 1'b0;
      end else begin
         qclk_ff <= clkdiv_ff[`BPAG_CLKDIV_W-1];
      end
   end

   // ------------------------------------------------------------------
   // per-pin drivers and read masks
   // ------------------------------------------------------------------

   for (genvar i = 0; i < `BPAG_PINS; i++) begin : g_pin
      always_comb begin
         if (i == `BPAG_PIN_QCLK && p6_mode == BPAG_P6_QCLK) begin
            nxt_pad_oe[i]  = 1'b1;
            nxt_pad_out[i] = clkdiv_ff[`BPAG_CLKDIV_W-1];
         end else if (alt_owned[i]) begin
            nxt_pad_oe[i]  = 1'b0;
            nxt_pad_out[i] = 1'b0;
         end else if (dir_ff[i]) begin
            // analog pins keep direction control too
            nxt_pad_oe[i]  = 1'b0;
            nxt_pad_out[i] = 1'b0;
         end else begin
            nxt_pad_oe[i]  = 1'b1;
            nxt_pad_out[i] = latch_ff[i];
         end
      end

      // analog, reference and oscillator use read low at the port; direction and latch read low only under the oscillator
      assign pin_read[i]   = pin_sync[i] && !analog_pin[i] && !alt_owned[i];
      assign dir_read[i]   = dir_ff[i] && !osc_owned[i];
      assign latch_read[i] = latch_ff[i] && !osc_owned[i];
   end

   // pad drive registered so the pins see no decode glitches
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pad_oe  <= '0;
         pad_out <= '0;
      end else begin
         pad_oe  <= nxt_pad_oe;
         pad_out <= nxt_pad_out;
      end
   end

   // ------------------------------------------------------------------
   // peripheral side outputs
   // ------------------------------------------------------------------

   // timer clock sees the raw synced level; slave select only while pin 5 is an input
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         timer_ext_clk_in <= 1'b0;
         timer_clk_valid  <= 1'b0;
      end else begin
         timer_ext_clk_in <= pin_sync[`BPAG_PIN_TMR];
         timer_clk_valid  <= dir_ff[`BPAG_PIN_TMR];
      end
   end

   // slave select held inactive while pin 5 is an output
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sync_serial_periph_ss_n <= 1'b1;
      end else if (dir_ff[`BPAG_PIN_SS]) begin
         sync_serial_periph_ss_n <= pin_sync[`BPAG_PIN_SS];
      end else begin
         sync_serial_periph_ss_n <= 1'b1;
      end
   end

   // analog-side enables; software must keep these pins as inputs
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         analog_ch_en <= '0;
         vref_cfg     <= '0;
      end else begin
         analog_ch_en <= {analog_pin[`BPAG_PIN_SS], analog_pin[3:0]};
         vref_cfg     <= adc_ctrl1_ff[`BPAG_VREF_MSB:`BPAG_VREF_LSB];
      end
   end

   // comparator reference output on pin 0
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cmp_ref_out_en <= 1'b0;
      end else begin
         cmp_ref_out_en <= cref_en_ff;
      end
   end

   // oscillator ownership of the two top pins
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         osc_in_en  <= 1'b0;
         osc_out_en <= 1'b0;
      end else begin
         osc_in_en  <= !p7_port;
         osc_out_en <= (p6_mode == BPAG_P6_OSC);
      end
   end

   // quarter-rate clock for on-chip users; one cycle behind the pin
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         clk_out_quarter <= 1'b0;
      end else begin
         clk_out_quarter <= qclk_ff;
      end
   end

   // ------------------------------------------------------------------
   // register reads
   // ------------------------------------------------------------------

   always_comb begin
      if (bus_addr == `BPAG_OFF_PIN_LEVEL) begin
         nxt_rdata = pin_read;
      end else if (bus_addr == `BPAG_OFF_OUT_LATCH) begin
         nxt_rdata = latch_read;
      end else if (bus_addr == `BPAG_OFF_DIR) begin
         nxt_rdata = dir_read;
      end else if (bus_addr == `BPAG_OFF_ADC_CTRL1) begin
         nxt_rdata = {2'h0, adc_ctrl1_ff};
      end else if (bus_addr == `BPAG_OFF_OSC_CFG) begin
         nxt_rdata = {4'h0, osc_cfg_ff};
      end else if (bus_addr == `BPAG_OFF_ALT_CTRL) begin
         nxt_rdata = {7'h00, cref_en_ff};
      end else if (bus_addr == `BPAG_OFF_OWN_STAT) begin
         // pins currently unavailable to the port
         nxt_rdata = alt_owned | (analog_pin & ~alt_owned);
      end else begin
         nxt_rdata = 8'h00;
      end
   end

   // read data stands for exactly one cycle after the strobe
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_ff <= 8'h00;
      end else if (bus_rd) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign bus_rdata = rdata_ff;

endmodule

// [verification/bpag_port_monitor.sv]
/* checker of the port block: bus read timing, pin drive and ownership
   assumes binding to bpag_port, one clock, asynchronous active-low reset */
`timescale 1ns/1ns
module bpag_port_monitor
   import bpag_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       resetn,
   input wire logic [2:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic       bus_wr,
   input wire logic       bus_rd,
   input wire logic [7:0] bus_rdata,
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [4:0] analog_ch_en,
   input wire logic       cmp_ref_out_en,
   input wire logic       osc_in_en,
   input wire logic       clk_out_quarter
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_rd_data_idle: assert property (!bus_rd |=> bus_rdata == 8'h00)
      else $error("read data not idle");
   a_dir_tristate: assert property (
      bus_wr && bus_addr == 3'h2 && bus_wdata == 8'hFF |=> ##1 (pad_oe & 8'h3F) == 8'h00)
      else $error("driver on with direction input");
   a_latch_drive: assert property (
      bus_wr && bus_addr <= 3'h1 ##1 !(bus_wr && bus_addr <= 3'h1)
      |=> ((pad_out ^ $past(bus_wdata, 2)) & pad_oe & 8'h3F) == 8'h00)
      else $error("driven pin differs from latch");
   a_ref_owns_pin: assert property (cmp_ref_out_en && $past(cmp_ref_out_en) |-> !pad_oe[0])
      else $error("pin 0 driven under reference");
   a_osc_owns_pin: assert property (osc_in_en [*2] |-> !pad_oe[7])
      else $error("pin 7 driven under oscillator");
   a_clk_quarter: assert property (
      $rose(clk_out_quarter) |=> clk_out_quarter ##1 !clk_out_quarter [*2] ##1 clk_out_quarter)
      else $error("clock out not a quarter rate");
   a_analog_reads_low: assert property (
      bus_rd && bus_addr == 3'h0 && !$past(bus_wr && bus_addr == 3'h3) |=>
      (bus_rdata & {2'b00, $past(analog_ch_en[4]), 1'b0, $past(analog_ch_en[3:0])}) == 8'h00)
      else $error("analog pin read high");
   a_reset_defaults: assert property (
      $rose(resetn) |=> analog_ch_en == 5'h1F && pad_oe == 8'h00)
      else $error("wrong state after reset");
   c_ref: cover property (cmp_ref_out_en);
   c_osc_both: cover property (osc_in_en && clk_out_quarter);
   c_unmapped: cover property (bus_rd && bus_addr == 3'h7);
endmodule

// [verification/bpag_pad_model.sv]
/* pin-side model: resolves each pad from the block driver and a far-side driver
   assumes the bench sets far-side value and enable; floating pads toggle each cycle */
`timescale 1ns/1ns
module bpag_pad_model (
   input  wire logic       core_clk,
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe,
   input  wire logic [7:0] far_val,
   input  wire logic [7:0] far_en,
   output logic      [7:0] pad_in
);
   logic [7:0] float_ff = 8'h55;
   always_ff @(posedge core_clk) begin
      float_ff <= ~float_ff;
   end
   // block driver wins, then far side, else a wandering level
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pad_in[i] = pad_oe[i] ? pad_out[i] : (far_en[i] ? far_val[i] : float_ff[i]);
      end
   end
endmodule

// [verification/tb_bidirectional_port_a_gpio.sv]
/* self-checking bench of the port block, one task per scenario
   assumes bpag_port, bpag_pad_model and bpag_port_monitor are compiled first */
`timescale 1ns/1ns
module tb_bidirectional_port_a_gpio;
   import bpag_pkg::*;
   logic       core_clk  = 1'b0;
   logic       resetn    = 1'b0;
   logic [2:0] bus_addr  = 3'h0;
   logic [7:0] bus_wdata = 8'h00;
   logic       bus_wr    = 1'b0;
   logic       bus_rd    = 1'b0;
   logic [7:0] far_val   = 8'hFF;
   logic [7:0] far_en    = 8'hFF;
   wire logic [7:0] bus_rdata, pad_in, pad_out, pad_oe;
   wire logic [4:0] analog_ch_en;
   wire logic [1:0] vref_cfg;
   wire logic tmr_clk, tmr_ok, ss_n, ref_en, osc_in_en, osc_out_en, clk_q;
   int n_fail = 0;
   int compares = 0;
   bpag_port u_dut (.core_clk(core_clk), .resetn(resetn), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .timer_ext_clk_in(tmr_clk),
      .timer_clk_valid(tmr_ok), .sync_serial_periph_ss_n(ss_n), .analog_ch_en(analog_ch_en),
      .vref_cfg(vref_cfg), .cmp_ref_out_en(ref_en), .osc_in_en(osc_in_en),
      .osc_out_en(osc_out_en), .clk_out_quarter(clk_q));
   bpag_pad_model u_pads (.core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe),
      .far_val(far_val), .far_en(far_en), .pad_in(pad_in));
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge core_clk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
      @(posedge core_clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge core_clk);
      bus_rd <= 1'b0;
      #1 chk(what, bus_rdata, exp);
   endtask
   task automatic pads(input logic [7:0] v, input logic [7:0] en);
      @(posedge core_clk);
      far_val <= v;
      far_en <= en;
      repeat (4) @(posedge core_clk);
      #1;
   endtask
   task automatic t_reset();
      rd(3'h2, 8'hFF, "dir reset");
      rd(3'h1, 8'h00, "latch reset");
      rd(3'h0, 8'hD0, "pins after reset");
      rd(3'h3, 8'h00, "adc reset");
      chk("oe reset", pad_oe, 8'h00);
      $display("t_reset done");
   endtask
   task automatic t_drive();
      wr(3'h3, 8'h0F);
      wr(3'h0, 8'hA5);
      wr(3'h2, 8'h00);
      pads(8'h00, 8'h00);
      chk("oe all out", pad_oe, 8'hFF);
      chk("drive", pad_out, 8'hA5);
      rd(3'h1, 8'hA5, "latch read");
      wr(3'h1, 8'h5A);
      rd(3'h0, 8'hA5, "pins lag");
      pads(8'h00, 8'h00);
      rd(3'h0, 8'h5A, "pins driven");
      $display("t_drive done");
   endtask
   task automatic t_input();
      wr(3'h2, 8'hFF);
      pads(8'h3C, 8'hFF);
      chk("oe off", pad_oe, 8'h00);
      rd(3'h0, 8'h3C, "pin read");
      chk("timer clk", tmr_clk, 1'b1);
      chk("ss high", ss_n, 1'b1);
      pads(8'hC3, 8'hFF);
      chk("timer clk low", tmr_clk, 1'b0);
      chk("timer ok", tmr_ok, 1'b1);
      chk("ss low", ss_n, 1'b0);
      wr(3'h2, 8'hCF);
      pads(8'hC3, 8'hFF);
      chk("ss output pin", ss_n, 1'b1);
      chk("timer output pin", tmr_ok, 1'b0);
      $display("t_input done");
   endtask
   task automatic t_analog();
      logic [4:0] m;
      wr(3'h2, 8'hFF);
      for (int p = 0; p < 16; p++) begin
         for (int k = 0; k < 5; k++) m[k] = (p <= 14 - k);
         wr(3'h3, {2'b10, 4'(p)});
         pads(8'hFF, 8'hFF);
         chk("analog select", analog_ch_en, m);
         chk("vref", vref_cfg, 2'h2);
         rd(3'h0, ~{2'b00, m[4], 1'b0, m[3:0]}, "analog read");
      end
      wr(3'h3, 8'h0F);
      $display("t_analog done");
   endtask
   task automatic t_ref();
      wr(3'h1, 8'hFF);
      wr(3'h2, 8'h00);
      wr(3'h5, 8'h01);
      pads(8'hFF, 8'hFF);
      chk("ref on", ref_en, 1'b1);
      chk("ref oe", pad_oe[0], 1'b0);
      rd(3'h0, 8'hFE, "ref read");
      rd(3'h6, 8'h01, "ref owned");
      wr(3'h5, 8'h00);
      $display("t_ref done");
   endtask
   task automatic t_osc();
      logic [3:0] code [5] = '{4'h8, 4'h9, 4'h5, 4'h4, 4'h0};
      logic [1:0] own  [5] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b11};
      wr(3'h2, 8'hFF);
      for (int i = 0; i < 5; i++) begin
         wr(3'h4, {4'h0, code[i]});
         pads(8'hFF, 8'hFF);
         chk("osc in", osc_in_en, own[i][1]);
         chk("osc out", osc_out_en, i == 4);
         chk("quarter pin drive", pad_oe[6], i == 1 || i == 3);
         rd(3'h2, {~own[i], 6'h3F}, "dir owned");
         rd(3'h1, {~own[i], 6'h3F}, "latch owned");
         rd(3'h0, {~own[i], 6'h3F}, "port owned");
         rd(3'h6, {own[i], 6'h00}, "owned");
      end
      wr(3'h4, 8'h08);
      $display("t_osc done");
   endtask
   task automatic t_unmapped();
      wr(3'h2, 8'h3C);
      wr(3'h7, 8'hC3);
      rd(3'h7, 8'h00, "unmapped");
      rd(3'h2, 8'h3C, "dir kept");
      @(posedge core_clk);
      #1 chk("rdata idle", bus_rdata, 8'h00);
      $display("t_unmapped done");
   endtask
   task automatic t_clk_quarter();
      int hi = 0;
      int flips = 0;
      logic prev_q;
      logic prev_pin;
      wr(3'h4, 8'h09);
      pads(8'hFF, 8'hFF);
      prev_q = clk_q;
      prev_pin = pad_out[6];
      for (int c = 0; c < 8; c++) begin
         @(posedge core_clk);
         #1;
         chk("quarter follows pin", clk_q, prev_pin);
         hi += clk_q;
         flips += (clk_q != prev_q);
         prev_q = clk_q;
         prev_pin = pad_out[6];
      end
      chk("quarter highs", 8'(hi), 8'h04);
      chk("quarter flips", 8'(flips), 8'h04);
      chk("quarter drive", pad_oe[6], 1'b1);
      wr(3'h4, 8'h08);
      $display("t_clk_quarter done");
   endtask
   task automatic finish_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      t_reset();
      t_drive();
      t_input();
      t_analog();
      t_ref();
      t_osc();
      t_clk_quarter();
      t_unmapped();
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      finish_test();
   end
endmodule
bind bpag_port bpag_port_monitor u_mon (.core_clk(core_clk), .resetn(resetn),
   .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_rdata(bus_rdata), .pad_out(pad_out), .pad_oe(pad_oe), .analog_ch_en(analog_ch_en),
   .cmp_ref_out_en(cmp_ref_out_en), .osc_in_en(osc_in_en), .clk_out_quarter(clk_out_quarter));
